//--- gps_clkdiv.sv
`timescale 1ns/10ps
`include "gps_defines.svh"
module gps_clkdiv (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Source clocks as sampled levels.
  input wire logic src_sel_in,
  input wire logic ext_clk_in,
  input wire logic osc_clk_in,
  // Divided clock.
  output logic clk_out
);
  logic [`GPS_DIV_W-1:0] cnt;
  logic [`GPS_DIV_W-1:0] next_cnt;
  logic prev_src;
  logic next_prev_src;
  logic next_clk;
  logic src;

  always_comb begin
    src = src_sel_in ? osc_clk_in : ext_clk_in;
    next_cnt = cnt;
    next_clk = clk_out;
    next_prev_src = prev_src;
    if (ce_in) begin
      next_prev_src = src;
      // Two source rises per half period give divide by four.
      if (src && !prev_src) begin
        next_cnt = cnt + 2'h1;
        if (cnt[0]) begin
          next_clk = ~clk_out;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= '0;
      clk_out <= 1'b0;
      prev_src <= 1'b0;
    end else begin
      cnt <= next_cnt;
      clk_out <= next_clk;
      prev_src <= next_prev_src;
    end
  end
endmodule

//--- gps_defines.svh
`ifndef GPS_DEFINES_SVH
`define GPS_DEFINES_SVH

// Register byte addresses on the Avalon-MM slave (word index times four).
`define GPS_ADDR_DIR 4'h0
`define GPS_ADDR_DATA 4'h4
`define GPS_ADDR_STRAP 4'h8
`define GPS_ADDR_CTRL 4'hc
`define GPS_ADDR_W 4

// Reset values.
`define GPS_DIR_RST 8'h00
`define GPS_DATA_RST 8'h00

// Strap register fields.
`define GPS_STRAP_BOOT_LSB 0
`define GPS_STRAP_BOOT_MSB 2
`define GPS_STRAP_CLKSRC 3
`define GPS_STRAP_SERSEL 4
`define GPS_STRAP_DONE 5

// Control register fields.
`define GPS_CTRL_BOOTDONE 0
`define GPS_CTRL_CLKSRC 1

// Pin positions.
`define GPS_PIN_SP0 3
`define GPS_PIN_HSK 4
`define GPS_PIN_SP2 5
`define GPS_PIN_SERSEL 7

// Edges after reset release before the synchronised straps are valid.
`define GPS_SYNC_FILL 2'h2

// Fast peripheral clock divider.
`define GPS_CLK_DIV 3'h4
`define GPS_DIV_W 2

`endif

//--- gps_pins.sv
`timescale 1ns/10ps
module gps_pins (
  // Clock.
  input wire logic clk_in,
  // Device and board drive.
  input wire logic [7:0] dev_out_in,
  input wire logic [7:0] dev_oe_in,
  input wire logic [7:0] ext_val_in,
  input wire logic [7:0] ext_oe_in,
  input wire logic quiet_in,
  // Resolved level.
  output logic [7:0] pin_out
);
  logic [7:0] last = 8'h00;
  logic [7:0] brd_oe;
  assign brd_oe = ext_oe_in & ~{3'h0, quiet_in, 4'h0};
  // Undriven pins settle at the inverse of their last driven level.
  assign pin_out = (dev_oe_in & dev_out_in) | (~dev_oe_in & brd_oe & ext_val_in)
    | (~dev_oe_in & ~brd_oe & ~last);
  always @(posedge clk_in) last <= ((dev_oe_in | brd_oe) & pin_out) | (~(dev_oe_in | brd_oe) & last);
endmodule

//--- gps_pkg.sv
package gps_pkg;
  typedef enum logic [1:0] {
    GPS_ST_RESET = 2'b00,
    GPS_ST_BOOT = 2'b01,
    GPS_ST_RUN = 2'b11
  } gps_state_t;
endpackage

//--- gps_props.sv
`timescale 1ns/10ps
`include "gps_defines.svh"
module gps_props (
  // Clock and reset.
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  // Bus.
  input wire logic [`GPS_ADDR_W-1:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  input wire logic [31:0] AVS_READDATA_OUT,
  input wire logic AVS_WAITREQUEST_OUT,
  input wire logic AVS_RESPONSE_ERR_OUT,
  // Pins and boot.
  input wire logic [7:0] GPIO_IN,
  input wire logic [7:0] GPIO_OE_OUT,
  input wire logic BOOT_HSK_EN_IN,
  input wire logic BOOT_DONE_IN,
  input wire logic [2:0] BOOT_MODE_SELECT_OUT,
  input wire logic CLOCK_SOURCE_SELECT_OUT
);
  logic [3:0] cnt, next_cnt;
  logic [7:0] strap, next_strap;
  logic booted, next_booted;
  logic dir_wr;
  assign dir_wr = AVS_WRITE_IN && AVS_ADDRESS_IN == `GPS_ADDR_DIR;
  always_comb begin
    next_cnt = cnt + {3'h0, cnt != 4'hf};
    next_strap = (cnt == 4'h0) ? GPIO_IN : strap;
    next_booted = booted | BOOT_DONE_IN | (AVS_WRITE_IN && AVS_BYTEENABLE_IN[0]
      && AVS_ADDRESS_IN == `GPS_ADDR_CTRL && AVS_WRITEDATA_IN[0]);
  end
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cnt <= 4'h0;
      strap <= 8'h00;
      booted <= 1'b0;
    end else begin
      cnt <= next_cnt;
      strap <= next_strap;
      booted <= next_booted;
    end
  end
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  a_wait_low: assert property (AVS_WAITREQUEST_OUT
    |-> AVS_READ_IN ##1 !AVS_WAITREQUEST_OUT) else $error("read waited too long");
  a_oe_reset: assert property (cnt == 4'h0
    |-> GPIO_OE_OUT == {3'h0, BOOT_HSK_EN_IN, 4'h0}) else $error("pin driven after reset");
  a_dir_oe: assert property (dir_wr && AVS_BYTEENABLE_IN[0]
    |=> GPIO_OE_OUT[7:6] == $past(AVS_WRITEDATA_IN[7:6])) else $error("direction not applied");
  a_lane_guard: assert property (dir_wr && !AVS_BYTEENABLE_IN[0]
    |=> $stable(GPIO_OE_OUT[7:6])) else $error("disabled lane wrote direction");
  a_err_map: assert property (AVS_READ_IN || AVS_WRITE_IN
    |=> AVS_RESPONSE_ERR_OUT == ($past(AVS_ADDRESS_IN[1:0]) != 2'h0)) else $error("error flag wrong");
  a_upper_zero: assert property (AVS_READDATA_OUT[31:8] == 24'h0)
    else $error("upper read bits set");
  a_mode_strap: assert property (cnt == 4'h8 |-> BOOT_MODE_SELECT_OUT == strap[2:0])
    else $error("boot mode differs from pins");
  a_clk_src: assert property (cnt == 4'h8 && !strap[4] |-> !CLOCK_SOURCE_SELECT_OUT)
    else $error("clock source not cleared");
  a_straps_held: assert property (cnt > 4'h8 |-> $stable(BOOT_MODE_SELECT_OUT))
    else $error("boot mode changed after reset");
  a_hsk_drive: assert property (!booted && cnt == 4'hf && BOOT_HSK_EN_IN
    && $past(BOOT_HSK_EN_IN) |-> GPIO_OE_OUT[4]) else $error("handshake pin not driven");
  c_hsk: cover property (!booted && GPIO_OE_OUT[4]);
  c_err: cover property (AVS_RESPONSE_ERR_OUT);
  c_boot: cover property ($rose(booted));
  c_rd_wait: cover property (AVS_READ_IN && AVS_WAITREQUEST_OUT);
endmodule
bind gps_top gps_props gps_props_i (.SYS_CLK_IN, .RST_N_IN, .AVS_ADDRESS_IN, .AVS_READ_IN,
  .AVS_WRITE_IN, .AVS_WRITEDATA_IN, .AVS_BYTEENABLE_IN, .AVS_READDATA_OUT,
  .AVS_WAITREQUEST_OUT, .AVS_RESPONSE_ERR_OUT, .GPIO_IN, .GPIO_OE_OUT, .BOOT_HSK_EN_IN,
  .BOOT_DONE_IN, .BOOT_MODE_SELECT_OUT, .CLOCK_SOURCE_SELECT_OUT);

//--- gps_sync.sv
`timescale 1ns/10ps
module gps_sync (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Data.
  input wire logic [7:0] d_in,
  output logic [7:0] q_out
);
  logic [7:0] stage1;
  logic [7:0] next_stage1;
  logic [7:0] next_q;

  always_comb begin
    next_stage1 = ce_in ? d_in : stage1;
    next_q = ce_in ? stage1 : q_out;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1 <= 8'h00;
      q_out <= 8'h00;
    end else begin
      stage1 <= next_stage1;
      q_out <= next_q;
    end
  end
endmodule

//--- gps_top.sv
// Functional notes
// - Each of the eight pins has its own direction bit.
// - Data reads return input levels; written values drive output pins.
// - All pins become inputs after reset.
// - Pins 2 to 0 are sampled after reset as boot mode code.
// - Boot strap pins are ordinary I/O once booting finishes.
// - Pin 4 may drive boot handshake; board must not drive it then.
// - After bootload, software may reconfigure pin 4 freely.
// - Serial pin zero is bit 3 if pin 7 low, else transmit clock; the code drives transmit clock there only once booting finishes.
// - Serial pin two is transmit frame sync if pin 7 high at reset; the code drives frame sync there only once booting finishes.
// - Strap functions are fixed at the rising edge of reset.
// - Pin 4 low at reset clears the clock source select bit.
// - Fast peripheral clock is selected source divided by four.
//
// The register addresses and the Avalon-MM slave port were decided locally.
`timescale 1ns/10ps
`include "gps_defines.svh"
module gps_top (
  // Clock, reset and enable.
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  // Avalon-MM slave.
  input wire logic [`GPS_ADDR_W-1:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  output logic AVS_RESPONSE_ERR_OUT,
  // General-purpose pins.
  input wire logic [7:0] GPIO_IN,
  output logic [7:0] GPIO_OUT,
  output logic [7:0] GPIO_OE_OUT,
  // Boot loader side.
  input wire logic BOOT_HSK_EN_IN,
  input wire logic BOOT_HSK_VAL_IN,
  input wire logic BOOT_DONE_IN,
  // Serial port two transmit signals.
  input wire logic SER2_CLK_IN,
  input wire logic SER2_CLK_OE_IN,
  input wire logic SER2_FS_IN,
  input wire logic SER2_FS_OE_IN,
  output logic SER2_CLK_PIN_OUT,
  output logic SER2_FS_PIN_OUT,
  // Clock sources and results.
  input wire logic EXT_CLK_IN,
  input wire logic OSC_CLK_IN,
  output logic FAST_PERIPH_CLK_OUT,
  output logic [2:0] BOOT_MODE_SELECT_OUT,
  output logic CLOCK_SOURCE_SELECT_OUT
);
  logic [7:0] pin_sync;
  logic [7:0] pin_direction_register;
  logic [7:0] pin_data_register;
  logic [7:0] next_dir;
  logic [7:0] next_data;
  logic [2:0] boot_mode_select;
  logic [2:0] next_boot_mode;
  logic serial_select;
  logic next_serial_select;
  logic clock_source_select_bit;
  logic next_clksrc;
  logic sw_boot_done;
  logic next_sw_boot_done;
  logic [1:0] clk_sync;
  logic [1:0] clk_meta;
  gps_pkg::gps_state_t state;
  gps_pkg::gps_state_t next_state;
  logic [31:0] next_rdata;
  logic next_err;
  logic boot_active;
  logic [7:0] drive_mask;
  logic [7:0] wmask;
  logic [7:0] wbyte;
  logic [7:0] pin_view;
  logic access;
  logic rd_ack;
  logic next_rd_ack;
  logic [1:0] fill;
  logic [1:0] next_fill;

  // Byte-lane write merge shared by the direction and data registers.
  // Bits whose lane is disabled keep their old value.
  function automatic logic [7:0] gps_merge(input logic [7:0] old, input logic [7:0] val,
    input logic [7:0] mask);
    return (val & mask) | (old & ~mask);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  gps_sync u_pin_sync (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RST_N_IN),
    .ce_in(CE_IN),
    .d_in(GPIO_IN),
    .q_out(pin_sync)
  );

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      clk_meta <= 2'h0;
      clk_sync <= 2'h0;
    end else if (CE_IN) begin
      clk_meta <= {OSC_CLK_IN, EXT_CLK_IN};
      clk_sync <= clk_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture and boot sequencing.

  always_comb begin
    next_state = state;
    next_boot_mode = boot_mode_select;
    next_serial_select = serial_select;
    next_clksrc = clock_source_select_bit;
    next_fill = fill;
    if (CE_IN) begin
      unique case (state)
        gps_pkg::GPS_ST_RESET: begin
          // The synchronisers restart empty, so the levels seen at reset release
          // reach their second stage only after a few edges.
          next_fill = fill + 2'h1;
          if (fill == `GPS_SYNC_FILL) begin
            next_boot_mode = pin_sync[`GPS_STRAP_BOOT_MSB:`GPS_STRAP_BOOT_LSB];
            next_serial_select = pin_sync[`GPS_PIN_SERSEL];
            next_clksrc = pin_sync[`GPS_PIN_HSK];
            next_state = gps_pkg::GPS_ST_BOOT;
          end
        end
        gps_pkg::GPS_ST_BOOT: begin
          if (BOOT_DONE_IN || sw_boot_done) begin
            next_state = gps_pkg::GPS_ST_RUN;
          end
        end
        gps_pkg::GPS_ST_RUN: begin
          next_state = gps_pkg::GPS_ST_RUN;
        end
        default: begin
          next_state = gps_pkg::GPS_ST_RESET;
        end
      endcase
      if (access && AVS_WRITE_IN && AVS_ADDRESS_IN == `GPS_ADDR_CTRL && AVS_BYTEENABLE_IN[0]) begin
        next_clksrc = AVS_WRITEDATA_IN[`GPS_CTRL_CLKSRC];
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state <= gps_pkg::GPS_ST_RESET;
      boot_mode_select <= 3'h0;
      serial_select <= 1'b0;
      clock_source_select_bit <= 1'b0;
      fill <= 2'h0;
    end else begin
      state <= next_state;
      boot_mode_select <= next_boot_mode;
      serial_select <= next_serial_select;
      clock_source_select_bit <= next_clksrc;
      fill <= next_fill;
    end
  end

  // Boot functions stay active until BOOT_DONE_IN or the software done bit moves the sequencer to run.
  assign boot_active = (state != gps_pkg::GPS_ST_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Register file on Avalon-MM.

  // A read waits one cycle so that its data stand registered at the edge where
  // waitrequest is sampled low.
  // A write never waits and lands at its first edge.
  assign AVS_WAITREQUEST_OUT = AVS_READ_IN && !rd_ack;
  assign access = CE_IN && ((AVS_READ_IN && !rd_ack) || AVS_WRITE_IN);
  assign wbyte = AVS_WRITEDATA_IN[7:0];
  assign wmask = {8{AVS_BYTEENABLE_IN[0]}};

  always_comb begin
    next_dir = pin_direction_register;
    next_data = pin_data_register;
    next_sw_boot_done = sw_boot_done;
    next_rdata = AVS_READDATA_OUT;
    next_err = AVS_RESPONSE_ERR_OUT;
    next_rd_ack = rd_ack;
    // The flag marks only the second cycle of a read, so reads issued back to
    // back each wait once.
    if (CE_IN) begin
      next_rd_ack = AVS_READ_IN && !rd_ack;
    end
    if (access) begin
      next_rdata = 32'h0000_0000;
      next_err = 1'b0;
      unique case (AVS_ADDRESS_IN)
        `GPS_ADDR_DIR: begin
          if (AVS_WRITE_IN) begin
            next_dir = gps_merge(pin_direction_register, wbyte, wmask);
          end
          next_rdata[7:0] = pin_direction_register;
        end
        `GPS_ADDR_DATA: begin
          if (AVS_WRITE_IN) begin
            next_data = gps_merge(pin_data_register, wbyte, wmask);
          end
          next_rdata[7:0] = pin_view;
        end
        `GPS_ADDR_STRAP: begin
          next_rdata[`GPS_STRAP_BOOT_MSB:`GPS_STRAP_BOOT_LSB] = boot_mode_select;
          next_rdata[`GPS_STRAP_CLKSRC] = clock_source_select_bit;
          next_rdata[`GPS_STRAP_SERSEL] = serial_select;
          next_rdata[`GPS_STRAP_DONE] = ~boot_active;
        end
        `GPS_ADDR_CTRL: begin
          if (AVS_WRITE_IN && AVS_BYTEENABLE_IN[0] && AVS_WRITEDATA_IN[`GPS_CTRL_BOOTDONE]) begin
            next_sw_boot_done = 1'b1;
          end
          next_rdata[`GPS_CTRL_BOOTDONE] = sw_boot_done;
          next_rdata[`GPS_CTRL_CLKSRC] = clock_source_select_bit;
        end
        default: begin
          next_err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pin_direction_register <= `GPS_DIR_RST;
      pin_data_register <= `GPS_DATA_RST;
      sw_boot_done <= 1'b0;
      rd_ack <= 1'b0;
      AVS_READDATA_OUT <= 32'h0000_0000;
      AVS_RESPONSE_ERR_OUT <= 1'b0;
    end else begin
      pin_direction_register <= next_dir;
      pin_data_register <= next_data;
      sw_boot_done <= next_sw_boot_done;
      rd_ack <= next_rd_ack;
      AVS_READDATA_OUT <= next_rdata;
      AVS_RESPONSE_ERR_OUT <= next_err;
    end
  end

  // Output pins read back their driven value, inputs their synchronised level.
  assign pin_view = (pin_direction_register & pin_data_register) |
                    (~pin_direction_register & pin_sync);

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers and serial sharing.

  always_comb begin
    drive_mask = pin_direction_register;
    GPIO_OUT = pin_data_register;
    if (serial_select && !boot_active) begin
      drive_mask[`GPS_PIN_SP0] = SER2_CLK_OE_IN;
      GPIO_OUT[`GPS_PIN_SP0] = SER2_CLK_IN;
    end
    if (serial_select && !boot_active) begin
      drive_mask[`GPS_PIN_SP2] = SER2_FS_OE_IN;
      GPIO_OUT[`GPS_PIN_SP2] = SER2_FS_IN;
    end
    if (boot_active) begin
      drive_mask[`GPS_PIN_HSK] = BOOT_HSK_EN_IN;
      GPIO_OUT[`GPS_PIN_HSK] = BOOT_HSK_VAL_IN;
    end
    GPIO_OE_OUT = drive_mask;
    SER2_CLK_PIN_OUT = serial_select & pin_sync[`GPS_PIN_SP0];
    SER2_FS_PIN_OUT = serial_select & pin_sync[`GPS_PIN_SP2];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fast peripheral clock.

  gps_clkdiv u_clkdiv (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RST_N_IN),
    .ce_in(CE_IN),
    .src_sel_in(clock_source_select_bit),
    .ext_clk_in(clk_sync[0]),
    .osc_clk_in(clk_sync[1]),
    .clk_out(FAST_PERIPH_CLK_OUT)
  );

  assign BOOT_MODE_SELECT_OUT = boot_mode_select;
  assign CLOCK_SOURCE_SELECT_OUT = clock_source_select_bit;
endmodule

//--- gps_top_tb.sv
`timescale 1ns/10ps
`include "gps_defines.svh"
module gps_top_tb;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, hq = 0, hen = 0, hv = 0, done = 0;
  logic sc = 0, sco = 0, sf = 0, sfo = 0, eclk = 0, oclk = 1;
  logic [3:0] adr = 0, ben = 0;
  logic [31:0] wd = 0, rdata;
  logic [7:0] ev = 8'h25, eo = 8'hff, pins, gout, goe, r, d;
  logic w_o, err_o, fclk, cs, fp, sp0, sp2;
  logic [2:0] bm;
  logic [15:0] seed = 16'h7123;
  logic [7:0] q[$];
  int error_cnt = 0, n_checks = 0, nt;
  always #2 clk = ~clk;
  always #32 eclk = ~eclk;
  always #48 oclk = ~oclk;
  gps_pins gps_pins_i (.clk_in(clk), .dev_out_in(gout), .dev_oe_in(goe), .ext_val_in(ev),
    .ext_oe_in(eo), .quiet_in(hq), .pin_out(pins));
  gps_top gps_top_i (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(1'b1), .AVS_ADDRESS_IN(adr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(ben),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(w_o), .AVS_RESPONSE_ERR_OUT(err_o),
    .GPIO_IN(pins), .GPIO_OUT(gout), .GPIO_OE_OUT(goe), .BOOT_HSK_EN_IN(hen),
    .BOOT_HSK_VAL_IN(hv), .BOOT_DONE_IN(done), .SER2_CLK_IN(sc), .SER2_CLK_OE_IN(sco),
    .SER2_FS_IN(sf), .SER2_FS_OE_IN(sfo), .SER2_CLK_PIN_OUT(sp0), .SER2_FS_PIN_OUT(sp2),
    .EXT_CLK_IN(eclk), .OSC_CLK_IN(oclk), .FAST_PERIPH_CLK_OUT(fclk),
    .BOOT_MODE_SELECT_OUT(bm), .CLOCK_SOURCE_SELECT_OUT(cs));
  function logic [7:0] xs();
    seed = seed ^ (seed << 7);
    seed = seed ^ (seed >> 9);
    seed = seed ^ (seed << 8);
    return seed[7:0];
  endfunction
  task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wrap_up();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Read data stand at the edge where waitrequest is sampled low.
  always @(posedge clk) begin
    if (rd && w_o === 1'b0) chk("readdata", q.pop_front(), rdata[7:0]);
  end
  task bus(input logic w, input logic [3:0] a, input logic [7:0] v, input logic [3:0] b);
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= {24'h0, v};
    ben <= b;
    @(posedge clk);
    while (w_o !== 1'b0) @(posedge clk);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task rdc(input logic [3:0] a, input logic [7:0] e);
    q.push_back(e);
    bus(1'b0, a, 8'h00, 4'h1);
  endtask
  task run(input logic [7:0] s);
    @(posedge clk);
    {ev, eo, hen, sco, sfo, rst_n} <= {s, 8'hff, 4'h0};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge clk);
    chk("boot_mode", {5'h0, s[2:0]}, {5'h0, bm});
    chk("clk_src", {7'h0, s[4]}, {7'h0, cs});
    rdc(`GPS_ADDR_STRAP, {3'h0, s[7], s[4], s[2:0]});
    rdc(`GPS_ADDR_DIR, 8'h00);
    bus(1'b1, 4'h6, 8'hff, 4'h1);
    #1 chk("err", 8'h01, {7'h0, err_o});
    @(posedge clk);
    {hq, hen, hv} <= 3'h7;
    repeat (3) @(posedge clk);
    chk("hsk", 8'h03, {6'h0, goe[4], pins[4]});
    hen <= 1'b0;
    @(posedge clk);
    {done, eo} <= {1'b1, 8'h00};
    @(posedge clk);
    {done, hq} <= 2'h0;
    d = s[7] ? 8'hd7 : 8'hff;
    r = xs();
    bus(1'b1, `GPS_ADDR_DIR, d, 4'h1);
    bus(1'b1, `GPS_ADDR_DATA, r, 4'h1);
    #1 chk("drive", r & d, pins & goe);
    bus(1'b1, `GPS_ADDR_DIR, 8'h00, 4'h0);
    rdc(`GPS_ADDR_DIR, d);
    bus(1'b1, `GPS_ADDR_DIR, 8'h00, 4'h1);
    r = xs() & d;
    {ev, eo} <= {r, 8'hff};
    repeat (4) @(posedge clk);
    rdc(`GPS_ADDR_DATA, r);
    {sc, sco, sf, sfo} <= 4'hf;
    repeat (4) @(posedge clk);
    chk("serial", {6'h0, {2{s[7]}}}, {6'h0, goe[5], goe[3]});
    chk("ser_in", {6'h0, {2{s[7]}}}, {6'h0, sp2, sp0});
    nt = 0;
    fp = fclk;
    repeat (640) begin
      @(posedge clk);
      nt += int'(fclk !== fp);
      fp = fclk;
    end
    chk("fclk", 8'h01, {7'h0, nt >= (s[4] ? 12 : 19) && nt <= (s[4] ? 14 : 21)});
  endtask
  initial begin
    run(8'h25);
    run(8'hb2);
    repeat (4) @(posedge clk);
    wrap_up();
  end
  initial begin
    #40000;
    error_cnt++;
    wrap_up();
  end
endmodule
